/* phymr_attr_mem.sv */
// Purpose: Attribute store with registered read data.
// Assumes: One write and one read port on the same clock.
// Notes: Read data appear the cycle after rd_en.
`timescale 1ns/1ps
module phymr_attr_mem #(
   parameter int DEPTH = 16,
   parameter int ID_W = 8,
   parameter int VAL_W = 16
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic [ID_W-1:0] wr_id,
   input wire logic [VAL_W-1:0] wr_val,
   input wire logic rd_en,
   input wire logic [ID_W-1:0] rd_id,
   output logic [VAL_W-1:0] rd_val
);
   logic [VAL_W-1:0] store [DEPTH];

   always_ff @(posedge clock) begin
      if (wr_en) begin
         store[wr_id[$clog2(DEPTH)-1:0]] <= wr_val;
      end
      if (rd_en) begin
         rd_val <= store[rd_id[$clog2(DEPTH)-1:0]];
      end
   end
endmodule

/* phymr_defines.svh */
// Purpose: Constants for the PHY management request handler.
// Assumes: 50 MHz clock, byte-addressed word registers.
// Notes: Offsets, fields, codes and timing only.
`ifndef PHYMR_DEFINES_SVH
`define PHYMR_DEFINES_SVH

`define PHYMR_OFS_CMD 8'h00
`define PHYMR_OFS_STATUS 8'h04
`define PHYMR_OFS_ATTR 8'h08
`define PHYMR_OFS_ZCT 8'h0C
`define PHYMR_OFS_TEST 8'h10
`define PHYMR_OFS_ATTR_WR 8'h14

`define PHYMR_CMD_MSB 2
`define PHYMR_CMD_LSB 0
`define PHYMR_TEN_BIT 8
`define PHYMR_TMODE_BIT 9
`define PHYMR_TMOD_MSB 12
`define PHYMR_TMOD_LSB 10
`define PHYMR_TLVL_MSB 15
`define PHYMR_TLVL_LSB 13
`define PHYMR_ID_MSB 23
`define PHYMR_ID_LSB 16
`define PHYMR_VAL_MSB 15
`define PHYMR_VAL_LSB 0

`define PHYMR_CMD_RESET 3'h1
`define PHYMR_CMD_SLEEP 3'h2
`define PHYMR_CMD_WAKE 3'h3
`define PHYMR_CMD_TEST 3'h4
`define PHYMR_CMD_ATTR 3'h5

`define PHYMR_RES_OK 2'h0
`define PHYMR_RES_FAIL 2'h1
`define PHYMR_RES_ALREADY 2'h2

`define PHYMR_MOD_UNUSED_A 3'h3
`define PHYMR_MOD_UNUSED_B 3'h7
`define PHYMR_LVL_STEP_DB 5'h03

`define PHYMR_CLK_PERIOD_NS 20
`define PHYMR_TICK_NS 10000
`define PHYMR_TIME_W 20

`endif

/* phymr_dp_model.sv */
// Purpose: Datapath stand-in holding pending transmissions and mains input.
// Assumes: Same clock as the handler.
// Notes: A burst lasts 12 cycles and only drains while transmit is enabled.
`timescale 1ns/1ps
module phymr_dp_model (
   input wire logic clock,
   input wire logic tx_enable,
   input wire logic flush_queues,
   input wire logic start_tx,
   input wire logic fault_req,
   input wire logic zc_req,
   output logic tx_pending,
   output logic impl_fault,
   output logic zero_cross_pin
);
   logic [3:0] left = 4'h0;
   assign tx_pending = left != 4'h0;
   assign impl_fault = fault_req;
   assign zero_cross_pin = zc_req;
   always @(posedge clock) begin
      if (flush_queues) begin
         left <= 4'h0;
      end else if (start_tx) begin
         left <= 4'hC;
      end else if (tx_pending && tx_enable) begin
         left <= left - 4'h1;
      end
   end
endmodule

/* phymr_handler.sv */
// Purpose: PHY management request/confirm handler with zero-cross timing.
// Assumes: Plain register port; tx_pending and impl_fault from same clock.
// Notes: One request in flight; each accepted request gets exactly one confirm.
`timescale 1ns/1ps
`include "phymr_defines.svh"
module phymr_handler
   import phymr_pkg::*;
#(
   parameter int ATTR_DEPTH = 16,
   parameter int TICK_CYC = `PHYMR_TICK_NS / `PHYMR_CLK_PERIOD_NS
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic tx_pending,
   input wire logic impl_fault,
   input wire logic zero_cross_pin,
   output logic tx_enable,
   output logic rx_enable,
   output logic flush_queues,
   output logic test_active,
   output phymr_test_cfg_t test_cfg,
   output logic [4:0] test_atten_db,
   output logic busy,
   output logic cfm_strobe,
   output phymr_cfm_t cfm
);
   localparam int TW = `PHYMR_TIME_W;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DRAIN,
      ST_EXEC,
      ST_READ
   } phymr_state_t;

   function automatic logic [4:0] level_to_db(input logic [2:0] code);
      level_to_db = 5'(code) * `PHYMR_LVL_STEP_DB;
   endfunction

   function automatic logic mod_unused(input logic [2:0] code);
      mod_unused = (code == `PHYMR_MOD_UNUSED_A) || (code == `PHYMR_MOD_UNUSED_B);
   endfunction

   phymr_state_t state;
   phymr_state_t next_state;
   phymr_op_t op;
   logic [2:0] cmd_q;
   logic ten_q;
   phymr_test_cfg_t tcfg_q;
   logic [7:0] id_q;
   logic done_flag;
   logic [15:0] attr_val_q;
   logic [7:0] attr_id_q;
   logic [TW-1:0] now;
   logic [TW-1:0] zct;
   logic [$clog2(TICK_CYC)-1:0] prescale;
   logic zc_s1;
   logic zc_s2;
   logic zc_s3;
   logic [15:0] mem_val;

   // Register port decode
   wire cmd_wr = wr && (addr == `PHYMR_OFS_CMD);
   wire attr_wr = wr && (addr == `PHYMR_OFS_ATTR_WR);
   wire status_rd = rd && (addr == `PHYMR_OFS_STATUS);
   wire [2:0] wr_cmd = wdata[`PHYMR_CMD_MSB:`PHYMR_CMD_LSB];
   wire [7:0] wr_id = wdata[`PHYMR_ID_MSB:`PHYMR_ID_LSB];
   wire cmd_known = (wr_cmd >= `PHYMR_CMD_RESET) && (wr_cmd <= `PHYMR_CMD_ATTR);
   // Unknown codes and writes while busy are dropped, never confirmed
   wire accept = cmd_wr && cmd_known && (state == ST_IDLE);
   wire mem_rd = accept && (wr_cmd == `PHYMR_CMD_ATTR);
   wire mem_wr = attr_wr && (32'(wr_id) < ATTR_DEPTH);
   wire id_bad = 32'(id_q) >= ATTR_DEPTH;

   wire is_reset = cmd_q == `PHYMR_CMD_RESET;
   wire is_sleep = cmd_q == `PHYMR_CMD_SLEEP;
   wire is_wake = cmd_q == `PHYMR_CMD_WAKE;
   wire is_test = cmd_q == `PHYMR_CMD_TEST;
   wire already = (is_sleep && op == OP_SLEEP)
      || (is_wake && op == OP_NORMAL)
      || (is_test && ten_q && op == OP_TEST);
   // Bad modulation code is refused as a failure rather than guessed
   wire test_bad = is_test && ten_q && mod_unused(tcfg_q.modulation);

   logic finish;
   logic [1:0] fin_res;
   logic apply;

   always_comb begin
      next_state = state;
      finish = 1'b0;
      fin_res = `PHYMR_RES_OK;
      apply = 1'b0;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               case (wr_cmd)
                  `PHYMR_CMD_SLEEP: next_state = ST_DRAIN;
                  `PHYMR_CMD_TEST: next_state = ST_DRAIN;
                  `PHYMR_CMD_ATTR: next_state = ST_READ;
                  default: next_state = ST_EXEC;
               endcase
            end
         end
         ST_DRAIN: begin
            // Pending transmissions finish before sleep or test
            if (!tx_pending || already) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            finish = 1'b1;
            next_state = ST_IDLE;
            if (already) begin
               fin_res = `PHYMR_RES_ALREADY;
            end else if (impl_fault || test_bad) begin
               fin_res = `PHYMR_RES_FAIL;
            end else begin
               fin_res = `PHYMR_RES_OK;
               apply = 1'b1;
            end
         end
         ST_READ: begin
            finish = 1'b1;
            next_state = ST_IDLE;
            if (impl_fault) begin
               fin_res = `PHYMR_RES_FAIL;
            end else if (id_bad) begin
               fin_res = `PHYMR_RES_ALREADY;
            end else begin
               fin_res = `PHYMR_RES_OK;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   wire soft_reset = apply && is_reset;

   // Read mux
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            `PHYMR_OFS_STATUS: next_rdata = {16'h0000, 5'h00, cfm.cmd, 2'h0,
               cfm.result, 2'(op), done_flag, busy};
            `PHYMR_OFS_ATTR: next_rdata = {8'h00, attr_id_q, attr_val_q};
            `PHYMR_OFS_ZCT: next_rdata = {12'h000, zct};
            `PHYMR_OFS_TEST: next_rdata = {15'h0000, test_cfg.level,
               test_cfg.modulation, test_cfg.half_duty, 1'b0, test_active, 8'h00};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   phymr_attr_mem #(
      .DEPTH(ATTR_DEPTH),
      .ID_W(8),
      .VAL_W(16)
   ) u_attr_mem (
      .clock(clock),
      .wr_en(mem_wr),
      .wr_id(wr_id),
      .wr_val(wdata[`PHYMR_VAL_MSB:`PHYMR_VAL_LSB]),
      .rd_en(mem_rd),
      .rd_id(wr_id),
      .rd_val(mem_val)
   );

   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= next_rdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Request capture
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cmd_q <= 3'h0;
         ten_q <= 1'b0;
         tcfg_q <= '0;
         id_q <= 8'h00;
      end else begin
         if (accept) begin
            cmd_q <= wr_cmd;
            ten_q <= wdata[`PHYMR_TEN_BIT];
            tcfg_q.half_duty <= wdata[`PHYMR_TMODE_BIT];
            tcfg_q.modulation <= wdata[`PHYMR_TMOD_MSB:`PHYMR_TMOD_LSB];
            tcfg_q.level <= wdata[`PHYMR_TLVL_MSB:`PHYMR_TLVL_LSB];
            id_q <= wr_id;
         end
      end
   end

   // Confirm output: one strobe per accepted request
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cfm_strobe <= 1'b0;
         cfm <= '0;
      end else begin
         cfm_strobe <= finish;
         if (finish) begin
            cfm.cmd <= cmd_q;
            cfm.result <= fin_res;
         end
      end
   end

   // New confirm beats a status read in the same cycle
   always_ff @(posedge clock) begin
      if (!rstn) begin
         done_flag <= 1'b0;
      end else if (finish) begin
         done_flag <= 1'b1;
      end else if (status_rd) begin
         done_flag <= 1'b0;
      end
   end

   // Value reads as zero whenever the status is not success
   wire attr_done = finish && (state == ST_READ);
   wire attr_bad = impl_fault || id_bad;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         attr_val_q <= 16'h0000;
         attr_id_q <= 8'h00;
      end else if (attr_done) begin
         attr_id_q <= id_q;
         attr_val_q <= attr_bad ? 16'h0000 : mem_val;
      end
   end

   // Flush pulse lines up with the successful reset confirm
   always_ff @(posedge clock) begin
      if (!rstn) begin
         flush_queues <= 1'b0;
      end else begin
         flush_queues <= soft_reset;
      end
   end

   // Operating state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         op <= OP_NORMAL;
      end else if (soft_reset) begin
         op <= OP_NORMAL;
      end else if (apply && is_sleep) begin
         op <= OP_SLEEP;
      end else if (apply && is_wake) begin
         op <= OP_NORMAL;
      end else if (apply && is_test && ten_q) begin
         op <= OP_TEST;
      end else if (apply && is_test) begin
         op <= OP_NORMAL;
      end
   end

   // Settings stay readable after test mode ends, until a soft reset clears them
   always_ff @(posedge clock) begin
      if (!rstn) begin
         test_cfg <= '0;
         test_atten_db <= 5'h00;
      end else if (soft_reset) begin
         test_cfg <= '0;
         test_atten_db <= 5'h00;
      end else if (apply && is_test && ten_q) begin
         test_cfg <= tcfg_q;
         test_atten_db <= level_to_db(tcfg_q.level);
      end
   end

   // Mains input: two flops before any logic, third marks the edge
   always_ff @(posedge clock) begin
      if (!rstn) begin
         zc_s1 <= 1'b0;
         zc_s2 <= 1'b0;
         zc_s3 <= 1'b0;
      end else begin
         zc_s1 <= zero_cross_pin;
         zc_s2 <= zc_s1;
         zc_s3 <= zc_s2;
      end
   end

   // Time base ticks every 10 us; soft reset leaves it running
   wire tick = 32'(prescale) == TICK_CYC - 1;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         prescale <= '0;
         now <= '0;
      end else if (tick) begin
         prescale <= '0;
         now <= now + 1'b1;
      end else begin
         prescale <= prescale + 1'b1;
      end
   end

   // Both mains edges are crossings; a crossing beats a soft reset
   wire zc_edge = zc_s2 != zc_s3;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         zct <= '0;
      end else if (zc_edge) begin
         zct <= now;
      end else if (soft_reset) begin
         zct <= '0;
      end
   end

   assign busy = state != ST_IDLE;
   assign tx_enable = op == OP_NORMAL;
   assign rx_enable = op == OP_NORMAL;
   assign test_active = op == OP_TEST;
endmodule

/* phymr_handler_chk.sv */
// Purpose: Port-level assertions for the management request handler.
// Assumes: Bound to phymr_handler; command codes 1..5 as in the defines.
// Notes: Checks confirm timing, pairing and op-state outputs.
`timescale 1ns/1ps
module phymr_handler_chk
   import phymr_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic tx_pending,
   input wire logic tx_enable,
   input wire logic rx_enable,
   input wire logic flush_queues,
   input wire logic test_active,
   input wire phymr_test_cfg_t test_cfg,
   input wire logic [4:0] test_atten_db,
   input wire logic busy,
   input wire logic cfm_strobe,
   input wire phymr_cfm_t cfm
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   wire take = wr && addr == 8'h00 && !busy && wdata[2:0] != 3'h0 && wdata[2:0] < 3'h6;
   // Reset, wake and attribute read never wait for the datapath
   wire fast = take && (wdata[2:0] == 3'h1 || wdata[2:0] == 3'h3 || wdata[2:0] == 3'h5);
   wire ok = cfm_strobe && cfm.result == 2'h0;

   AST_TAKE: assert property (take |=> busy)
      else $error("request not taken");
   AST_FAST: assert property (fast |=> ##1
      (cfm_strobe && cfm.cmd == $past(wdata[2:0], 2)))
      else $error("confirm late or wrong command");
   AST_PULSE: assert property (cfm_strobe |=> !cfm_strobe)
      else $error("confirm longer than one cycle");
   AST_DONE: assert property ($fell(busy) |-> cfm_strobe)
      else $error("busy ended without confirm");
   AST_FLUSH: assert property (flush_queues |-> ok && cfm.cmd == 3'h1)
      else $error("flush without successful reset");
   AST_RST_RES: assert property (cfm_strobe && cfm.cmd == 3'h1 |-> cfm.result < 2'h2)
      else $error("bad reset result");
   AST_SLEEP: assert property (cfm_strobe && cfm.cmd == 3'h2 && cfm.result != 2'h1
      |-> !rx_enable && !tx_enable)
      else $error("still active after sleep");
   AST_WAKE: assert property (cfm_strobe && cfm.cmd == 3'h3 && cfm.result != 2'h1
      |-> rx_enable && tx_enable)
      else $error("not running after wake");
   AST_DRAIN: assert property (ok && (cfm.cmd == 3'h2 || test_active)
      |-> !$past(tx_pending))
      else $error("entered before transmit drained");
   AST_ATTEN: assert property (test_active
      |-> test_atten_db == {2'h0, test_cfg.level} * 5'h03)
      else $error("attenuation mismatch");
   AST_MOD: assert property (test_active |-> test_cfg.modulation[1:0] != 2'h3)
      else $error("unused modulation active");

   COV_SLEEP: cover property (ok && cfm.cmd == 3'h2);
   COV_TEST: cover property (ok && test_active);
   COV_ATTR: cover property (cfm_strobe && cfm.cmd == 3'h5 && cfm.result == 2'h2);
endmodule

bind phymr_handler phymr_handler_chk phymr_handler_chk_i (.clock(clock), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .tx_pending(tx_pending), .tx_enable(tx_enable),
   .rx_enable(rx_enable), .flush_queues(flush_queues), .test_active(test_active),
   .test_cfg(test_cfg), .test_atten_db(test_atten_db), .busy(busy),
   .cfm_strobe(cfm_strobe), .cfm(cfm));

/* phymr_pkg.sv */
// Purpose: Shared types of the PHY management request handler.
// Assumes: Constants come from phymr_defines.svh.
// Notes: Types only.
package phymr_pkg;

   typedef enum logic [1:0] {
      OP_NORMAL,
      OP_SLEEP,
      OP_TEST
   } phymr_op_t;

   typedef struct packed {
      logic half_duty;
      logic [2:0] modulation;
      logic [2:0] level;
   } phymr_test_cfg_t;

   typedef struct packed {
      logic [2:0] cmd;
      logic [1:0] result;
   } phymr_cfm_t;

endpackage

/* testbench.sv */
// Purpose: Directed register-level test of the request handler.
// Assumes: Short time base tick so crossings resolve quickly.
// Notes: Requests are issued one at a time and await their confirm.
`timescale 1ns/1ps
module testbench;
   import phymr_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic start_tx = 1'b0;
   logic fault_req = 1'b0;
   logic zc_req = 1'b0;
   logic [31:0] rdata, v, w, t1;
   logic tx_pending, impl_fault, zero_cross_pin, tx_enable, rx_enable, flush_queues;
   logic test_active, busy, cfm_strobe, bad;
   logic [4:0] test_atten_db;
   phymr_test_cfg_t test_cfg;
   phymr_cfm_t cfm;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 clock = ~clock;
   phymr_handler #(.TICK_CYC(4)) phymr_handler_i (.clock(clock), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_pending(tx_pending),
      .impl_fault(impl_fault), .zero_cross_pin(zero_cross_pin), .tx_enable(tx_enable),
      .rx_enable(rx_enable), .flush_queues(flush_queues), .test_active(test_active),
      .test_cfg(test_cfg), .test_atten_db(test_atten_db), .busy(busy),
      .cfm_strobe(cfm_strobe), .cfm(cfm));
   phymr_dp_model phymr_dp_model_i (.clock(clock), .tx_enable(tx_enable),
      .flush_queues(flush_queues), .start_tx(start_tx), .fault_req(fault_req),
      .zc_req(zc_req), .tx_pending(tx_pending), .impl_fault(impl_fault),
      .zero_cross_pin(zero_cross_pin));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1;
      r = rdata;
   endtask
   // Bounded wait: a lost confirm shows up as a failed compare
   task automatic req(input logic [31:0] d, input logic [1:0] res);
      int n;
      wr_reg(8'h00, d);
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (cfm_strobe !== 1'b1 && n < 100);
      chk({cfm_strobe, cfm.cmd, cfm.result}, {1'b1, d[2:0], res});
   endtask
   // One-cycle burst request to the datapath stand-in
   task automatic pulse_tx;
      @(posedge clock);
      start_tx <= 1'b1;
      @(posedge clock);
      start_tx <= 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rd_reg(8'h04, v);
      chk(v, 32'h0);
      chk({tx_enable, rx_enable, busy}, 3'h6);
      req(32'h3, 2'h2);
      pulse_tx();
      req(32'h2, 2'h0);
      chk({tx_pending, tx_enable, rx_enable}, 3'h0);
      rd_reg(8'h04, v);
      chk(v, 32'h206);
      rd_reg(8'h04, v);
      chk(v, 32'h204);
      req(32'h2, 2'h2);
      req(32'h3, 2'h0);
      @(posedge clock);
      fault_req <= 1'b1;
      // Wake while running reports already ahead of a fault
      for (int c = 1; c < 6; c++) begin
         req(32'(c), (c == 3) ? 2'h2 : 2'h1);
      end
      @(posedge clock);
      fault_req <= 1'b0;
      chk({tx_enable, rx_enable}, 2'h3);
      pulse_tx();
      req(32'h1, 2'h0);
      @(posedge clock);
      #1;
      chk(tx_pending, 1'b0);
      for (int m = 0; m < 8; m++) begin
         bad = (m == 3 || m == 7);
         w = 32'h104 | ((7 - m) << 13) | (m << 10) | ((m & 1) << 9);
         if (m == 1) begin
            pulse_tx();
         end
         req(w, {1'b0, bad});
         rd_reg(8'h10, v);
         chk(v & (bad ? 32'h100 : 32'h1FF00),
            bad ? 32'h0 : 32'h100 | ((7 - m) << 14) | (m << 11) | ((m & 1) << 10));
         if (!bad) begin
            chk(test_atten_db, 32'((7 - m) * 3));
         end
         if (m == 0) begin
            req(w, 2'h2);
         end
         req(32'h4, 2'h0);
         chk({test_active, tx_enable}, 2'h1);
      end
      wr_reg(8'h14, 32'h0003BEEF);
      req(32'h00030005, 2'h0);
      rd_reg(8'h08, v);
      chk(v, 32'h0003BEEF);
      req(32'h00200005, 2'h2);
      rd_reg(8'h08, v);
      chk(v, 32'h00200000);
      rd_reg(8'h18, v);
      chk(v, 32'h0);
      wr_reg(8'h00, 32'h0);
      wr_reg(8'h00, 32'h6);
      @(posedge clock);
      #1;
      chk({busy, cfm_strobe}, 2'h0);
      @(posedge clock);
      zc_req <= 1'b1;
      repeat (20) @(posedge clock);
      rd_reg(8'h0C, t1);
      repeat (17) @(posedge clock);
      @(posedge clock);
      zc_req <= 1'b0;
      repeat (20) @(posedge clock);
      rd_reg(8'h0C, v);
      chk(v - t1, 32'h0000000A);
      give_verdict();
   end
endmodule
